//--- core/bst_pkg.sv
// Purpose: shared constants and types for the boundary-scan test logic
// Assumes: four-bit instruction register, 32-bit identification register
// Notes: chain lengths and identification fields are plain defaults

package bst_pkg;

    // instruction register
    localparam int IR_W = 4;
    localparam logic [3:0] IR_CAPTURE_PAT = 4'h1;
    localparam logic [3:0] INS_EXTEST = 4'h0;
    localparam logic [3:0] INS_IDENT = 4'h1;
    localparam logic [3:0] INS_HIGHZ = 4'h4;
    localparam logic [3:0] INS_SAMPLE = 4'h5;
    localparam logic [3:0] INS_BYPASS = 4'hf;

    // identification register layout
    localparam int ID_W = 32;
    localparam int ID_VER_LSB = 28;
    localparam int ID_PART_LSB = 12;
    localparam int ID_MAKER_LSB = 1;
    localparam logic ID_LSB_ONE = 1'b1;
    // arbitrary identity values, not tied to any real part
    localparam logic [3:0] ID_VER_DFLT = 4'h0;
    localparam logic [15:0] ID_PART_DFLT = 16'h1234;
    localparam logic [10:0] ID_MAKER_DFLT = 11'h0aa;

    // pin scan chain: input cells first (nearest tdo), output cells after
    localparam int PIN_IN_N = 8;
    localparam int PIN_OUT_N = 8;
    localparam int CHAIN_N = PIN_IN_N + PIN_OUT_N;

    // values after reset
    localparam logic BYPASS_CAPTURE = 1'b0;
    localparam logic [PIN_OUT_N-1:0] PIN_OUT_RST = 8'h00;

    typedef enum logic [3:0] {
        TAP_RESET,
        TAP_IDLE,
        TAP_SEL_DR,
        TAP_CAP_DR,
        TAP_SHIFT_DR,
        TAP_EXIT1_DR,
        TAP_PAUSE_DR,
        TAP_EXIT2_DR,
        TAP_UPD_DR,
        TAP_SEL_IR,
        TAP_CAP_IR,
        TAP_SHIFT_IR,
        TAP_EXIT1_IR,
        TAP_PAUSE_IR,
        TAP_EXIT2_IR,
        TAP_UPD_IR
    } bst_tap_state_t;

endpackage : bst_pkg

//--- core/bst_tap_logic.sv
// Purpose: test access port controller, instruction decode and test data registers
// Assumes: tck_in is the link clock; core_clk_in runs the pad muxes
// Notes: pad data crosses from tck by toggle handshake; modes by two flops
// Notes: mode decodes leave tck from flops; the pad image is sampled bit by bit

`timescale 1ns/100ps
`default_nettype none

module bst_tap_logic #(
    parameter logic [3:0] ID_VERSION = bst_pkg::ID_VER_DFLT,    // arbitrary value
    parameter logic [15:0] ID_PART = bst_pkg::ID_PART_DFLT,     // arbitrary value
    parameter logic [10:0] ID_MAKER = bst_pkg::ID_MAKER_DFLT    // arbitrary value
) (
    input wire logic core_clk_in,                               // core clock, 125 MHz
    input wire logic srst_in,                                   // core reset, sync, high
    input wire logic tck_in,                                    // test clock
    input wire logic tms_in,                                    // test mode select
    input wire logic tdi_in,                                    // test data in
    input wire logic trst_n_in,                                 // test reset, async, low
    output logic tdo_out,                                       // test data out
    output logic tdo_oe_out,                                    // tdo driven when high
    input wire logic [bst_pkg::PIN_IN_N-1:0] pad_in,            // levels at input pins
    output logic [bst_pkg::PIN_IN_N-1:0] core_pin_out,          // input pins to core
    input wire logic [bst_pkg::PIN_OUT_N-1:0] func_data_in,     // core output data
    input wire logic [bst_pkg::PIN_OUT_N-1:0] func_oe_in,       // core output enables
    output logic [bst_pkg::PIN_OUT_N-1:0] pad_data_out,         // data to output pins
    output logic [bst_pkg::PIN_OUT_N-1:0] pad_oe_out            // output pin enables
);
    import bst_pkg::*;

    // next controller state from tms
    // every state lists both exits; no code of the enum is illegal
    function automatic bst_tap_state_t tap_next(input bst_tap_state_t s, input logic tms);
        bst_tap_state_t n;
        n = s;
        unique case (s)
            TAP_RESET:    n = tms ? TAP_RESET : TAP_IDLE;
            TAP_IDLE:     n = tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR:   n = tms ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR:   n = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: n = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: n = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: n = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: n = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR:   n = tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR:   n = tms ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR:   n = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: n = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: n = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: n = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: n = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
            TAP_UPD_IR:   n = tms ? TAP_SEL_DR : TAP_IDLE;
        endcase
        return n;
    endfunction

    // instruction to data register selection
    // extest and sample/preload share the chain; nothing decodes a self-test
    function automatic logic ins_sel_chain(input logic [3:0] ins);
        return (ins == INS_EXTEST) || (ins == INS_SAMPLE);
    endfunction

    function automatic logic ins_sel_ident(input logic [3:0] ins);
        return ins == INS_IDENT;
    endfunction

    // pins released for highz and for every unlisted code
    function automatic logic ins_pins_off(input logic [3:0] ins);
        return !(ins_sel_chain(ins) || ins_sel_ident(ins) || (ins == INS_BYPASS));
    endfunction

    // ---------------- tck domain ----------------
    bst_tap_state_t state_q, state_d;
    logic [IR_W-1:0] ir_shift_q, ir_shift_d;
    logic [IR_W-1:0] ir_active_q, ir_active_d;
    logic bypass_q, bypass_d;
    logic [ID_W-1:0] id_shift_q, id_shift_d;
    logic [CHAIN_N-1:0] chain_q, chain_d;
    logic [PIN_OUT_N-1:0] chain_upd_q, chain_upd_d;
    logic upd_tgl_q, upd_tgl_d;
    logic tdo_q, tdo_d;
    logic tdo_oe_q, tdo_oe_d;
    logic [CHAIN_N-1:0] cap_meta_q, cap_sync_q;

    wire logic [ID_W-1:0] id_value;
    wire logic sel_chain;
    wire logic sel_ident;
    wire logic in_shift_dr;
    wire logic in_shift_ir;
    wire logic dr_serial_out;

    assign id_value = {ID_VERSION, ID_PART, ID_MAKER, ID_LSB_ONE};
    assign sel_chain = ins_sel_chain(ir_active_q);
    assign sel_ident = ins_sel_ident(ir_active_q);
    assign in_shift_dr = state_q == TAP_SHIFT_DR;
    assign in_shift_ir = state_q == TAP_SHIFT_IR;
    // bypass is the fallback path for every other code, self-test included
    assign dr_serial_out = sel_chain ? chain_q[0] :
                           sel_ident ? id_shift_q[0] : bypass_q;

    // rising-edge next values; everything holds unless its state acts
    always_comb begin
        state_d = tap_next(state_q, tms_in);
        ir_shift_d = ir_shift_q;
        bypass_d = bypass_q;
        id_shift_d = id_shift_q;
        chain_d = chain_q;
        unique case (state_q)
            TAP_CAP_IR: begin
                ir_shift_d = IR_CAPTURE_PAT;
            end
            TAP_SHIFT_IR: begin
                ir_shift_d = {tdi_in, ir_shift_q[IR_W-1:1]};
            end
            TAP_CAP_DR: begin
                if (sel_chain) begin
                    chain_d = cap_sync_q;
                end else if (sel_ident) begin
                    id_shift_d = id_value;
                end else begin
                    bypass_d = BYPASS_CAPTURE;
                end
            end
            TAP_SHIFT_DR: begin
                if (sel_chain) begin
                    chain_d = {tdi_in, chain_q[CHAIN_N-1:1]};
                end else if (sel_ident) begin
                    id_shift_d = {tdi_in, id_shift_q[ID_W-1:1]};
                end else begin
                    bypass_d = tdi_in;
                end
            end
            default: begin
            end
        endcase
    end

    // trst resets every shift stage at once (ir to its capture pattern, others to 0), whatever tck is doing
    always_ff @(posedge tck_in or negedge trst_n_in) begin
        if (!trst_n_in) begin
            state_q <= TAP_RESET;
            ir_shift_q <= IR_CAPTURE_PAT;
            bypass_q <= BYPASS_CAPTURE;
            id_shift_q <= '0;
            chain_q <= '0;
        end else begin
            state_q <= state_d;
            ir_shift_q <= ir_shift_d;
            bypass_q <= bypass_d;
            id_shift_q <= id_shift_d;
            chain_q <= chain_d;
        end
    end

    // falling-edge next values: update stages and tdo
    always_comb begin
        ir_active_d = ir_active_q;
        chain_upd_d = chain_upd_q;
        upd_tgl_d = upd_tgl_q;
        if (state_q == TAP_RESET) begin
            ir_active_d = INS_IDENT;
        end else if (state_q == TAP_UPD_IR) begin
            ir_active_d = ir_shift_q;
        end
        // bypass and identification leave the pin update stage alone
        if (state_q == TAP_UPD_DR && sel_chain) begin
            chain_upd_d = chain_q[CHAIN_N-1:PIN_IN_N];
            upd_tgl_d = ~upd_tgl_q;
        end
        tdo_oe_d = in_shift_dr || in_shift_ir;
        tdo_d = in_shift_ir ? ir_shift_q[0] : (in_shift_dr ? dr_serial_out : 1'b0);
    end

    // tdo moves half a period clear of the tester's rising-edge sample
    always_ff @(negedge tck_in or negedge trst_n_in) begin
        if (!trst_n_in) begin
            ir_active_q <= INS_IDENT;
            chain_upd_q <= PIN_OUT_RST;
            upd_tgl_q <= 1'b0;
            tdo_q <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else begin
            ir_active_q <= ir_active_d;
            chain_upd_q <= chain_upd_d;
            upd_tgl_q <= upd_tgl_d;
            tdo_q <= tdo_d;
            tdo_oe_q <= tdo_oe_d;
        end
    end

    // tdo reads 0 while released; the board's pull-up sets the line level
    assign tdo_out = tdo_q;
    assign tdo_oe_out = tdo_oe_q;

    // ---------------- core domain and crossings ----------------
    logic [PIN_IN_N-1:0] pad_meta_q, pad_sync_q;
    logic [CHAIN_N-1:0] cap_core_q;
    logic extest_meta_q, extest_sync_q;
    logic off_meta_q, off_sync_q;
    logic tgl_meta_q, tgl_sync_q, tgl_prev_q;
    logic [PIN_OUT_N-1:0] pin_upd_q;
    logic [PIN_OUT_N-1:0] pad_data_q, pad_data_d;
    logic [PIN_OUT_N-1:0] pad_oe_q, pad_oe_d;
    logic [PIN_IN_N-1:0] core_pin_q;

    wire logic mode_extest;
    wire logic mode_off;
    wire logic upd_seen;
    logic mode_extest_q;
    logic mode_off_q;

    // modes decode the next instruction into falling-edge flops: a decode of a
    // changing four-bit word may glitch, and the core side must never see that
    assign mode_extest = ir_active_d == INS_EXTEST;
    assign mode_off = ins_pins_off(ir_active_d);
    assign upd_seen = tgl_sync_q ^ tgl_prev_q;

    // flops follow ir_active_q: they move at update-ir and in reset only
    always_ff @(negedge tck_in or negedge trst_n_in) begin
        if (!trst_n_in) begin
            mode_extest_q <= 1'b0;
            mode_off_q <= 1'b0;
        end else begin
            mode_extest_q <= mode_extest;
            mode_off_q <= mode_off;
        end
    end

    // output mode muxes are the only shared logic with the application
    always_comb begin
        if (off_sync_q) begin
            pad_data_d = func_data_in;
            pad_oe_d = '0;
        end else if (extest_sync_q) begin
            pad_data_d = pin_upd_q;
            pad_oe_d = {PIN_OUT_N{1'b1}};
        end else begin
            pad_data_d = func_data_in;
            pad_oe_d = func_oe_in;
        end
    end

    // pad_in is asynchronous: two flops before anything reads it
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            pad_meta_q <= '0;
            pad_sync_q <= '0;
            cap_core_q <= '0;
            core_pin_q <= '0;
        end else begin
            pad_meta_q <= pad_in;
            pad_sync_q <= pad_meta_q;
            // chain image: output cells see the core's outgoing data
            cap_core_q <= {func_data_in, pad_sync_q};
            core_pin_q <= pad_sync_q;
        end
    end

    // mode flops are slow levels; two core flops are enough
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            extest_meta_q <= 1'b0;
            extest_sync_q <= 1'b0;
            off_meta_q <= 1'b0;
            off_sync_q <= 1'b0;
        end else begin
            extest_meta_q <= mode_extest_q;
            extest_sync_q <= extest_meta_q;
            off_meta_q <= mode_off_q;
            off_sync_q <= off_meta_q;
        end
    end

    // update stage copied on toggle; it stays put for many tck periods after
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            tgl_meta_q <= 1'b0;
            tgl_sync_q <= 1'b0;
            tgl_prev_q <= 1'b0;
            pin_upd_q <= PIN_OUT_RST;
        end else begin
            tgl_meta_q <= upd_tgl_q;
            tgl_sync_q <= tgl_meta_q;
            tgl_prev_q <= tgl_sync_q;
            if (upd_seen) begin
                pin_upd_q <= chain_upd_q;
            end
        end
    end

    // pads driven from flops so the pins never see a mux glitch
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            pad_data_q <= PIN_OUT_RST;
            pad_oe_q <= '0;
        end else begin
            pad_data_q <= pad_data_d;
            pad_oe_q <= pad_oe_d;
        end
    end

    // capture image into tck domain; pins are slow next to capture timing
    // limitation: bits cross one by one, so a word that changes within two
    // tck periods of capture-dr may be captured half old, half new
    always_ff @(posedge tck_in or negedge trst_n_in) begin
        if (!trst_n_in) begin
            cap_meta_q <= '0;
            cap_sync_q <= '0;
        end else begin
            cap_meta_q <= cap_core_q;
            cap_sync_q <= cap_meta_q;
        end
    end

    assign pad_data_out = pad_data_q;
    assign pad_oe_out = pad_oe_q;
    assign core_pin_out = core_pin_q;

endmodule : bst_tap_logic // bst_tap_logic

`default_nettype wire

//--- bench/bst_tap_logic_props.sv
// Purpose: checker on the tap pins and pad ports
// Assumes: tap state and instruction are tracked here from tms and tdi
// Notes: tdo values are judged at rising tck; tdo edge timing and pads on the core clock
`timescale 1ns/100ps
`default_nettype none
module bst_tap_logic_props #(
    parameter logic [3:0] ID_VERSION = bst_pkg::ID_VER_DFLT, // arbitrary value
    parameter logic [15:0] ID_PART = bst_pkg::ID_PART_DFLT, // arbitrary value
    parameter logic [10:0] ID_MAKER = bst_pkg::ID_MAKER_DFLT // arbitrary value
) (
    input wire logic core_clk_in, // core clock
    input wire logic srst_in, // core reset
    input wire logic tck_in, // test clock
    input wire logic tms_in, // mode select
    input wire logic tdi_in, // data in
    input wire logic trst_n_in, // test reset
    input wire logic tdo_out, // data out
    input wire logic tdo_oe_out, // tdo enable
    input wire logic [bst_pkg::PIN_IN_N-1:0] pad_in, // input pins
    input wire logic [bst_pkg::PIN_IN_N-1:0] core_pin_out, // pins to core
    input wire logic [bst_pkg::PIN_OUT_N-1:0] func_data_in, // core data
    input wire logic [bst_pkg::PIN_OUT_N-1:0] func_oe_in, // core enables
    input wire logic [bst_pkg::PIN_OUT_N-1:0] pad_data_out, // pin data
    input wire logic [bst_pkg::PIN_OUT_N-1:0] pad_oe_out // pin enables
);
    import bst_pkg::*;
    // next state, four bits per state, for tms high and for tms low
    localparam logic [63:0] NXT_HI = 64'h2fefcc0287855920;
    localparam logic [63:0] NXT_LO = 64'h1bddbba146644311;
    localparam logic [31:0] ID_EXP = {ID_VERSION, ID_PART, ID_MAKER, ID_LSB_ONE};
    logic [3:0] st_q, st_d, sh_q, ins_q;
    logic [7:0] cnt_q;
    logic [2:0] rc_q;
    wire logic sh_dr = st_q == TAP_SHIFT_DR;
    wire logic sh_ir = st_q == TAP_SHIFT_IR;
    wire logic cap = st_q == TAP_CAP_DR || st_q == TAP_CAP_IR;
    wire logic byp = !(ins_q inside {INS_EXTEST, INS_IDENT, INS_SAMPLE});
    assign st_d = tms_in ? NXT_HI[4*st_q +: 4] : NXT_LO[4*st_q +: 4];
    always_ff @(posedge tck_in or negedge trst_n_in) begin
        if (!trst_n_in) begin
            st_q <= 4'h0;
            cnt_q <= 8'h00;
            sh_q <= 4'h0;
            ins_q <= INS_IDENT;
        end else begin
            st_q <= st_d;
            cnt_q <= cap ? 8'h00 : cnt_q + 8'(sh_dr | sh_ir);
            sh_q <= sh_ir ? {tdi_in, sh_q[3:1]} : sh_q;
            ins_q <= (st_q == TAP_RESET) ? INS_IDENT : (st_q == TAP_UPD_IR) ? sh_q : ins_q;
        end
    end
    // counts core edges since reset left, so sync flops hold real pin data
    always_ff @(posedge core_clk_in) begin
        rc_q <= srst_in ? 3'h0 : rc_q + 3'(rc_q != 3'h3);
    end
    chk_oe_shift: assert property (@(posedge tck_in) disable iff (!trst_n_in)
        tdo_oe_out == (sh_dr || sh_ir)) else $error("tdo enable outside shift states");
    chk_tdo_quiet: assert property (@(posedge tck_in) disable iff (!trst_n_in)
        !tdo_oe_out |-> !tdo_out) else $error("tdo not low while released");
    chk_tdo_edge: assert property (@(posedge core_clk_in) disable iff (!trst_n_in)
        $changed(tdo_out) |-> !tck_in) else $error("tdo moved while tck high");
    chk_ir_capture: assert property (@(posedge tck_in) disable iff (!trst_n_in)
        sh_ir && cnt_q < 8'h04 |-> tdo_out == (cnt_q == 8'h00)) else $error("bad ir capture");
    chk_id_bits: assert property (@(posedge tck_in) disable iff (!trst_n_in)
        sh_dr && ins_q == INS_IDENT && cnt_q < 8'h20 |-> tdo_out == ID_EXP[cnt_q[4:0]])
        else $error("identification bit wrong");
    chk_byp_first: assert property (@(posedge tck_in) disable iff (!trst_n_in)
        sh_dr && byp && cnt_q == 8'h00 |-> !tdo_out) else $error("bypass first bit not zero");
    chk_byp_path: assert property (@(posedge tck_in) disable iff (!trst_n_in)
        sh_dr && $past(sh_dr) && byp && cnt_q != 8'h00 |-> tdo_out == $past(tdi_in))
        else $error("bypass path not one stage");
    chk_pad_reset: assert property (@(posedge core_clk_in)
        srst_in |=> pad_oe_out == 8'h00 && pad_data_out == 8'h00 && core_pin_out == 8'h00)
        else $error("pads not cleared by reset");
    chk_pin_pass: assert property (@(posedge core_clk_in) disable iff (srst_in)
        rc_q == 3'h3 |-> core_pin_out == $past(pad_in, 3)) else $error("core pins lag wrong");
    cov_highz: cover property (@(posedge tck_in) st_q == TAP_UPD_IR && sh_q == INS_HIGHZ);
    cov_pause: cover property (@(posedge tck_in) st_q == TAP_PAUSE_DR);
    cov_extest: cover property (@(posedge tck_in) sh_dr && ins_q == INS_EXTEST);
endmodule // bst_tap_logic_props
bind bst_tap_logic bst_tap_logic_props #(.ID_VERSION(ID_VERSION), .ID_PART(ID_PART),
    .ID_MAKER(ID_MAKER)) u_props (.core_clk_in(core_clk_in), .srst_in(srst_in),
    .tck_in(tck_in), .tms_in(tms_in), .tdi_in(tdi_in), .trst_n_in(trst_n_in),
    .tdo_out(tdo_out), .tdo_oe_out(tdo_oe_out), .pad_in(pad_in), .core_pin_out(core_pin_out),
    .func_data_in(func_data_in), .func_oe_in(func_oe_in), .pad_data_out(pad_data_out),
    .pad_oe_out(pad_oe_out));
`default_nettype wire

//--- bench/bst_tester.sv
// Purpose: board tester model driving the test access port
// Assumes: scans start and end in run-test/idle
// Notes: tck stands low between scans; tdi toggles outside shifts
`timescale 1ns/100ps
`default_nettype none
module bst_tester (
    output logic tck_out, // test clock
    output logic tms_out, // mode select
    output logic tdi_out, // data to device
    output logic trst_n_out, // test reset
    input wire logic tdo_in, // data from device
    input wire logic tdo_oe_in // device drives tdo
);
    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b0;
        trst_n_out = 1'b0;
    end
    // inputs move only just after falling tck, held over the rising edge
    task automatic tick(input logic tms, input logic tdi, output logic tdo);
        tms_out = tms;
        tdi_out = tdi;
        #62.5;
        tdo = tdo_oe_in ? tdo_in : 1'b1; // released line floats to its pull-up
        tck_out = 1'b1;
        #62.5;
        tck_out = 1'b0;
    endtask
    task automatic trst_pulse();
        logic d;
        trst_n_out = 1'b0;
        #100;
        trst_n_out = 1'b1;
        tick(1'b0, ~tdi_out, d);
    endtask
    task automatic tms_reset();
        logic d;
        repeat (5) tick(1'b1, ~tdi_out, d);
        tick(1'b0, ~tdi_out, d);
    endtask
    // pz names the bit after which the scan rests in pause
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
        input int pz, output logic [31:0] dout);
        logic d;
        dout = 32'h0;
        #1.7;
        tick(1'b1, ~tdi_out, d);
        if (ir) begin
            tick(1'b1, ~tdi_out, d);
        end
        repeat (2) tick(1'b0, ~tdi_out, d);
        for (int k = 0; k < n; k++) begin
            tick(k == n - 1 || k == pz, din[k], d);
            dout[k] = d;
            if (k == pz && k != n - 1) begin
                repeat (2) tick(1'b0, ~tdi_out, d);
                tick(1'b1, ~tdi_out, d);
                tick(1'b0, ~tdi_out, d);
            end
        end
        tick(1'b1, ~tdi_out, d);
        tick(1'b0, ~tdi_out, d);
    endtask
endmodule // bst_tester
`default_nettype wire

//--- bench/bst_tap_logic_test.sv
// Purpose: self-checking bench for the boundary-scan test logic
// Assumes: default identification parameters, pins held at fixed levels
// Notes: rows cover each instruction; reset and pause tests follow
`timescale 1ns/100ps
`default_nettype none
module bst_tap_logic_test;
    import bst_pkg::*;
    typedef struct packed {
        logic [3:0] ins;
        logic [5:0] n;
        logic [31:0] din;
        logic [31:0] dout;
        logic [31:0] mask;
        logic [7:0] oe;
        logic [7:0] dat;
    } bst_row_t;
    localparam logic [7:0] FD = 8'h3c;
    localparam logic [7:0] FO = 8'h5a;
    localparam logic [7:0] PI = 8'ha5;
    localparam logic [31:0] ID_EXP = {ID_VER_DFLT, ID_PART_DFLT, ID_MAKER_DFLT, ID_LSB_ONE};
    localparam logic [31:0] CAP = {16'h0, FD, PI};
    // output cells capture the core's outgoing data in every chain mode
    localparam bst_row_t ROWS [9] = '{
        '{INS_IDENT, 6'h20, 32'h0, ID_EXP, 32'hffffffff, FO, FD},
        '{INS_BYPASS, 6'h08, 32'hb6, 32'h6c, 32'hff, FO, FD},
        '{INS_SAMPLE, 6'h10, 32'h9600, CAP, 32'hffff, FO, FD},
        '{INS_EXTEST, 6'h00, 32'h0, 32'h0, 32'h0, 8'hff, 8'h96},
        '{INS_EXTEST, 6'h10, 32'h6900, CAP, 32'hffff, 8'hff, 8'h69},
        '{INS_HIGHZ, 6'h08, 32'h01, 32'h02, 32'hff, 8'h00, FD},
        '{4'h7, 6'h08, 32'h80, 32'h00, 32'hff, 8'h00, FD},
        '{4'h2, 6'h08, 32'hc1, 32'h82, 32'hff, 8'h00, FD},
        '{INS_BYPASS, 6'h08, 32'h55, 32'haa, 32'hff, FO, FD}};
    logic core_clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic [7:0] pad_in = PI;
    logic [7:0] func_data_in = FD;
    logic [7:0] func_oe_in = FO;
    logic tck_in, tms_in, tdi_in, trst_n_in, tdo_out, tdo_oe_out;
    logic [7:0] core_pin_out, pad_data_out, pad_oe_out;
    logic [31:0] got;
    int fail_count = 0;
    int checked = 0;
    int cyc = 0;
    always #4 core_clk_in = ~core_clk_in;
    bst_tap_logic u_bst_tap_logic (.core_clk_in(core_clk_in), .srst_in(srst_in),
        .tck_in(tck_in), .tms_in(tms_in), .tdi_in(tdi_in), .trst_n_in(trst_n_in),
        .tdo_out(tdo_out), .tdo_oe_out(tdo_oe_out), .pad_in(pad_in), .core_pin_out(core_pin_out),
        .func_data_in(func_data_in), .func_oe_in(func_oe_in), .pad_data_out(pad_data_out),
        .pad_oe_out(pad_oe_out));
    bst_tester u_bst_tester (.tck_out(tck_in), .tms_out(tms_in), .tdi_out(tdi_in),
        .trst_n_out(trst_n_in), .tdo_in(tdo_out), .tdo_oe_in(tdo_oe_out));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic load(input logic [3:0] ins);
        logic [31:0] o;
        u_bst_tester.scan(1'b1, 4, 32'(ins), 99, o);
        check(o & 32'hf, 32'(IR_CAPTURE_PAT), "ir capture");
    endtask
    // mode crosses to the core clock in a few cycles; twelve leaves margin
    task automatic pads(input logic [7:0] oe, input logic [7:0] dat);
        repeat (12) @(posedge core_clk_in);
        @(negedge core_clk_in);
        check(32'(pad_oe_out), 32'(oe), "pad enables");
        check(32'(pad_data_out), 32'(dat), "pad data");
    endtask
    always @(posedge core_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fail_count++;
            finish_test();
        end
    end
    initial begin
        repeat (20) @(posedge core_clk_in);
        srst_in <= 1'b0;
        @(negedge core_clk_in);
        check(32'(pad_oe_out | pad_data_out | core_pin_out), 32'h0, "reset pads");
        u_bst_tester.trst_pulse();
        for (int i = 0; i < 9; i++) begin
            load(ROWS[i].ins);
            if (ROWS[i].n != 6'h00) begin
                u_bst_tester.scan(1'b0, int'(ROWS[i].n), ROWS[i].din, 99, got);
                check(got & ROWS[i].mask, ROWS[i].dout, "dr out");
            end
            pads(ROWS[i].oe, ROWS[i].dat);
            check(32'(core_pin_out), 32'(PI), "core pins");
            $display("row %0d done", i);
        end
        for (int m = 0; m < 2; m++) begin
            load(INS_EXTEST);
            if (m == 0) begin
                u_bst_tester.tms_reset();
            end else begin
                u_bst_tester.trst_pulse();
            end
            pads(FO, FD);
            u_bst_tester.scan(1'b0, 32, 32'h0, 99, got);
            check(got, ID_EXP, "id after reset");
            $display("reset test %0d done", m);
        end
        load(INS_SAMPLE);
        u_bst_tester.scan(1'b0, 16, 32'h0, 5, got);
        check(got, CAP, "paused scan");
        $display("pause test done");
        finish_test();
    end
endmodule // bst_tap_logic_test
`default_nettype wire
